// file: design/mad_adv_regs.sv
`timescale 1ns/1ps
`include "mad_params.svh"
module mad_adv_regs
  import mad_pkg::*;
#(
  parameter mad_adv_type ADV = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // byte access from the management bus
  input wire logic rd_i,
  input wire logic wr_i,
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  // read answer
  output logic [7:0] rdata_o,
  output logic rvalid_o
);
  // ---------------------------------------------
  // advertised value checks
  // ---------------------------------------------
  // reserved duration codes fall back to the top defined range
  function automatic logic [3:0] dur_clip(
    input logic [3:0] code
  );
    if (code >= `MAD_DUR_RSVD) begin
      dur_clip = `MAD_DUR_TOP;
    end else begin
      dur_clip = code;
    end
  endfunction : dur_clip

  // reserved equalization kind reads as no information
  function automatic logic [1:0] eq_clip(
    input logic [1:0] kind
  );
    if (kind == `MAD_EQ_RSVD) begin
      eq_clip = `MAD_EQ_NONE;
    end else begin
      eq_clip = kind;
    end
  endfunction : eq_clip

  // ---------------------------------------------
  // select wait time byte
  // ---------------------------------------------
  // value is mantissa shifted left by exponent, in microseconds
  // zero exponent and mantissa pass through as no information
  function automatic logic [7:0] wait_byte(
    input mad_adv_type adv
  );
    logic [7:0] img;

    img = `MAD_ZERO_BYTE;
    img[`MAD_WAIT_EXP_HI:`MAD_WAIT_EXP_LO] = adv.wait_exponent;
    img[`MAD_WAIT_MAN_HI:`MAD_WAIT_MAN_LO] = adv.wait_mantissa;
    wait_byte = img;
  endfunction : wait_byte

  // ---------------------------------------------
  // state duration byte
  // ---------------------------------------------
  // worst-case figures over all datapath mixes are set at integration
  // codes above the top defined range are reserved
  function automatic logic [7:0] dur_byte(
    input mad_adv_type adv
  );
    logic [7:0] img;

    img = `MAD_ZERO_BYTE;
    img[`MAD_DUR_DEINIT_HI:`MAD_DUR_DEINIT_LO] = dur_clip(adv.deinit_duration_limit);
    img[`MAD_DUR_INIT_HI:`MAD_DUR_INIT_LO] = dur_clip(adv.init_duration_limit);
    dur_byte = img;
  endfunction : dur_byte

  // ---------------------------------------------
  // module characteristics byte
  // ---------------------------------------------
  // grouping code holds per bank of eight lanes
  // aux sources pick between two quantities each
  function automatic logic [7:0] char_byte(
    input mad_adv_type adv
  );
    logic [7:0] img;

    img = `MAD_ZERO_BYTE;
    img[`MAD_CHAR_COOL_BIT] = adv.transmitter_cooled;
    img[`MAD_CHAR_GRP_HI:`MAD_CHAR_GRP_LO] = adv.lane_sync_grouping;
    img[`MAD_CHAR_PULSE_BIT] = adv.pulse_timing_support;
    img[`MAD_CHAR_PAGE_BIT] = adv.timing_page_present;
    img[`MAD_CHAR_AUX3_BIT] = adv.aux_three_source;
    img[`MAD_CHAR_AUX2_BIT] = adv.aux_two_source;
    img[`MAD_CHAR_AUX1_BIT] = adv.aux_one_source;
    char_byte = img;
  endfunction : char_byte

  // ---------------------------------------------
  // case temperature bytes
  // ---------------------------------------------
  // signed whole degrees, both zero means unspecified
  function automatic logic [7:0] temp_byte(
    input mad_adv_type adv,
    input logic lower
  );
    logic [7:0] img;

    img = adv.case_temp_upper;
    if (lower) begin
      img = adv.case_temp_lower;
    end
    temp_byte = img;
  endfunction : temp_byte

  // ---------------------------------------------
  // cable latency bytes
  // ---------------------------------------------
  // high byte at the lower offset
  function automatic logic [7:0] latency_byte(
    input mad_adv_type adv,
    input logic low_half
  );
    logic [7:0] img;

    img = adv.cable_latency[`MAD_LAT_HI_MSB:`MAD_LAT_HI_LSB];
    if (low_half) begin
      img = adv.cable_latency[`MAD_LAT_LO_MSB:`MAD_LAT_LO_LSB];
    end
    latency_byte = img;
  endfunction : latency_byte

  // ---------------------------------------------
  // supply floor byte
  // ---------------------------------------------
  // count of voltage steps, zero means unspecified
  function automatic logic [7:0] floor_byte(
    input mad_adv_type adv
  );
    floor_byte = adv.supply_floor;
  endfunction : floor_byte

  // ---------------------------------------------
  // receiver characteristics byte
  // ---------------------------------------------
  // the two low bits belong to neighbouring fields and read as zero
  function automatic logic [7:0] rx_byte(
    input mad_adv_type adv
  );
    logic [7:0] img;

    img = `MAD_ZERO_BYTE;
    img[`MAD_RX_DET_BIT] = adv.photodetector_kind;
    img[`MAD_RX_EQ_HI:`MAD_RX_EQ_LO] = eq_clip(adv.rx_equalization_kind);
    img[`MAD_RX_PWR_BIT] = adv.rx_power_metric;
    img[`MAD_RX_LOS_BIT] = adv.rx_signal_loss_metric;
    img[`MAD_RX_FAST_BIT] = adv.rx_signal_loss_fast;
    img[`MAD_RX_PAD_HI:`MAD_RX_PAD_LO] = `MAD_RX_PAD;
    rx_byte = img;
  endfunction : rx_byte

  // ---------------------------------------------
  // address map
  // ---------------------------------------------
  // the block returns image data only for its own offsets
  function automatic logic in_map(
    input logic [7:0] addr
  );
    in_map = (addr >= `MAD_OFS_WAIT) &&
             (addr <= `MAD_OFS_RX);
  endfunction : in_map

  // ---------------------------------------------
  // timing byte images
  // ---------------------------------------------
  // one combinational image per advertised byte
  logic [7:0] img_wait;
  logic [7:0] img_dur;

  always_comb begin
    img_wait = wait_byte(ADV);
  end

  always_comb begin
    img_dur = dur_byte(ADV);
  end

  // ---------------------------------------------
  // module byte images
  // ---------------------------------------------
  logic [7:0] img_char;
  logic [7:0] img_tmax;
  logic [7:0] img_tmin;
  logic [7:0] img_lat_hi;
  logic [7:0] img_lat_lo;
  logic [7:0] img_vmin;

  always_comb begin
    img_char = char_byte(ADV);
  end

  always_comb begin
    img_tmax = temp_byte(ADV, 1'b0);
  end

  always_comb begin
    img_tmin = temp_byte(ADV, 1'b1);
  end

  always_comb begin
    img_lat_hi = latency_byte(ADV, 1'b0);
  end

  always_comb begin
    img_lat_lo = latency_byte(ADV, 1'b1);
  end

  always_comb begin
    img_vmin = floor_byte(ADV);
  end

  // ---------------------------------------------
  // receiver byte image
  // ---------------------------------------------
  logic [7:0] img_rx;

  always_comb begin
    img_rx = rx_byte(ADV);
  end

  // ---------------------------------------------
  // request qualification
  // ---------------------------------------------
  logic take_rd;

  // a read beside a write counts as a write
  always_comb begin
    take_rd = rd_i & ~wr_i;
  end

  // ---------------------------------------------
  // byte selection
  // ---------------------------------------------
  logic [7:0] sel;

  // offsets follow the byte order of the page
  // unmapped offsets read as zero
  always_comb begin
    sel = `MAD_ZERO_BYTE;
    if (!in_map(addr_i)) begin
      sel = `MAD_ZERO_BYTE;
    end else if (addr_i == `MAD_OFS_WAIT) begin
      sel = img_wait;
    end else if (addr_i == `MAD_OFS_DUR) begin
      sel = img_dur;
    end else if (addr_i == `MAD_OFS_CHAR) begin
      sel = img_char;
    end else if (addr_i == `MAD_OFS_TMAX) begin
      sel = img_tmax;
    end else if (addr_i == `MAD_OFS_TMIN) begin
      sel = img_tmin;
    end else if (addr_i == `MAD_OFS_LAT_HI) begin
      sel = img_lat_hi;
    end else if (addr_i == `MAD_OFS_LAT_LO) begin
      sel = img_lat_lo;
    end else if (addr_i == `MAD_OFS_VMIN) begin
      sel = img_vmin;
    end else if (addr_i == `MAD_OFS_RX) begin
      sel = img_rx;
    end
  end

  // ---------------------------------------------
  // answer state
  // ---------------------------------------------
  // read answer register, cleared by reset
  mad_state_type st_ff;
  mad_state_type nxt_st;

  // rdata holds between reads, rvalid pulses once per read
  // writes never reach the constants
  // no datapath control lives here
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rvalid = take_rd;
    if (take_rd) begin
      nxt_st.rdata = sel;
    end
  end

  // ---------------------------------------------
  // state register
  // ---------------------------------------------
  // reset clears the answer, the image itself is constant
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign rdata_o = st_ff.rdata;
  assign rvalid_o = st_ff.rvalid;
endmodule : mad_adv_regs

// file: design/mad_params.svh
// Notes on behaviour
// - wait time is exponent 7-5, mantissa 4-0
// - zero wait byte means no information
// - byte 144 holds deinit/init duration codes
// - duration codes 0-13 ranges, 14-15 reserved
// - duration maxima are worst case overall
// - byte 145 bit 7 reports transmitter cooling
// - bits 6-5 give lane synchronous grouping
// - grouping repeats per bank of eight lanes
// - bit 4 set only with pulse timing
// - bit 3 reports timing page presence
// - bits 2-0 select auxiliary monitor sources
// - bytes 146-147 signed case temperature limits
// - cable latency 16 bits, 10 ns units
// - byte 150 supply floor in 20 mV
// - byte 151 bits 6-5 equalization kind
// - bits 4,3 power and loss metrics
// - bit 2 reports fast signal loss
// - active datapaths undisturbed by group changes
`ifndef MAD_PARAMS_SVH
`define MAD_PARAMS_SVH
`define MAD_OFS_WAIT 8'h8f
`define MAD_OFS_DUR 8'h90
`define MAD_OFS_CHAR 8'h91
`define MAD_OFS_TMAX 8'h92
`define MAD_OFS_TMIN 8'h93
`define MAD_OFS_LAT_HI 8'h94
`define MAD_OFS_LAT_LO 8'h95
`define MAD_OFS_VMIN 8'h96
`define MAD_OFS_RX 8'h97
`define MAD_DUR_RSVD 4'he
`define MAD_EQ_RSVD 2'h3
`define MAD_ZERO_BYTE 8'h00
`define MAD_ZERO_WORD 16'h0000
`define MAD_DUR_TOP 4'hd
`define MAD_EQ_NONE 2'h0
`define MAD_RX_PAD 2'h0
`define MAD_WAIT_EXP_HI 7
`define MAD_WAIT_EXP_LO 5
`define MAD_WAIT_MAN_HI 4
`define MAD_WAIT_MAN_LO 0
`define MAD_DUR_DEINIT_HI 7
`define MAD_DUR_DEINIT_LO 4
`define MAD_DUR_INIT_HI 3
`define MAD_DUR_INIT_LO 0
`define MAD_CHAR_COOL_BIT 7
`define MAD_CHAR_GRP_HI 6
`define MAD_CHAR_GRP_LO 5
`define MAD_CHAR_PULSE_BIT 4
`define MAD_CHAR_PAGE_BIT 3
`define MAD_CHAR_AUX3_BIT 2
`define MAD_CHAR_AUX2_BIT 1
`define MAD_CHAR_AUX1_BIT 0
`define MAD_LAT_HI_MSB 15
`define MAD_LAT_HI_LSB 8
`define MAD_LAT_LO_MSB 7
`define MAD_LAT_LO_LSB 0
`define MAD_RX_DET_BIT 7
`define MAD_RX_EQ_HI 6
`define MAD_RX_EQ_LO 5
`define MAD_RX_PWR_BIT 4
`define MAD_RX_LOS_BIT 3
`define MAD_RX_FAST_BIT 2
`define MAD_RX_PAD_HI 1
`define MAD_RX_PAD_LO 0
`endif

// file: design/mad_pkg.sv
package mad_pkg;
  typedef struct packed {
    logic [2:0] wait_exponent;
    logic [4:0] wait_mantissa;
    logic [3:0] deinit_duration_limit;
    logic [3:0] init_duration_limit;
    logic transmitter_cooled;
    logic [1:0] lane_sync_grouping;
    logic pulse_timing_support;
    logic timing_page_present;
    logic aux_three_source;
    logic aux_two_source;
    logic aux_one_source;
    logic [7:0] case_temp_upper;
    logic [7:0] case_temp_lower;
    logic [15:0] cable_latency;
    logic [7:0] supply_floor;
    logic photodetector_kind;
    logic [1:0] rx_equalization_kind;
    logic rx_power_metric;
    logic rx_signal_loss_metric;
    logic rx_signal_loss_fast;
  } mad_adv_type;

  typedef struct packed {
    logic [7:0] rdata;
    logic rvalid;
  } mad_state_type;
endpackage : mad_pkg

// file: verification/mad_adv_regs_assertions.sv
`timescale 1ns/1ps
module mad_chk (
  input wire logic clk_i, arst_n_i, rd_i, wr_i, rvalid_o,
  input wire logic [7:0] addr_i, wdata_i, rdata_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  wire logic rq = rd_i && !wr_i;
  answer_due_a: assert property (rq |=> rvalid_o) else $error("no answer");
  answer_cause_a: assert property (rvalid_o |-> $past(rq)) else $error("stray answer");
  data_hold_a: assert property ($changed(rdata_o) |-> rvalid_o) else $error("data moved");
  write_quiet_a: assert property (wr_i |=> !rvalid_o) else $error("write answered");
  unmapped_zero_a: assert property (rq && (addr_i < 8'h8f || addr_i > 8'h97) |=> rdata_o == 8'h00)
    else $error("unmapped");
  dur_code_a: assert property (rq && addr_i == 8'h90 |=> rdata_o[7:4] < 4'he && rdata_o[3:0] < 4'he)
    else $error("reserved code");
  eq_kind_a: assert property (rq && addr_i == 8'h97 |=> rdata_o[6:5] != 2'h3) else $error("eq kind");
  low_bits_a: assert property (rq && addr_i == 8'h97 |=> rdata_o[1:0] == 2'h0) else $error("low bits");
endmodule : mad_chk
bind mad_adv_regs mad_chk u_chk (.*);

// file: verification/mad_host.sv
`timescale 1ns/1ps
module mad_host (
  input wire logic clk_i,
  output logic rd_o, wr_o,
  output logic [7:0] addr_o, wdata_o
);
  initial {rd_o, wr_o, addr_o, wdata_o} = '0;
  // no select line, so the wait time is met trivially
  task automatic access(input logic r, w, input logic [7:0] a, d);
    @(negedge clk_i);
    {rd_o, wr_o, addr_o, wdata_o} = {r, w, a, d};
  endtask : access
endmodule : mad_host

// file: verification/test_module_advertisement_fields.sv
`timescale 1ns/1ps
module test_module_advertisement_fields;
  import mad_pkg::*;
  localparam logic [69:0] ADV_C = {40'h2cfe_a946_fb, 16'h1234, 8'hb4, 6'h3a};
  logic clk_i = 0, arst_n_i = 0, rd_i, wr_i, rvalid_o;
  logic [7:0] addr_i, wdata_i, rdata_o, exp_q[$];
  int err_count = 0, checked = 0;
  always #12.5 clk_i = ~clk_i;
  mad_host host (.clk_i, .rd_o(rd_i), .wr_o(wr_i), .addr_o(addr_i), .wdata_o(wdata_i));
  mad_adv_regs #(.ADV(mad_adv_type'(ADV_C))) dut (.clk_i, .arst_n_i, .rd_i, .wr_i, .addr_i, .wdata_i,
    .rdata_o, .rvalid_o);
  function automatic logic [7:0] model(logic [7:0] a);
    logic [7:0] v;
    v = 8'h00;
    if (a >= 8'h8f && a <= 8'h96) v = ADV_C[69 - 8 * (a - 143) -: 8];
    if (a == 8'h97) v = {ADV_C[5:0], 2'h0};
    if (a == 8'h90) v = {(v[7:4] > 4'hd) ? 4'hd : v[7:4], (v[3:0] > 4'hd) ? 4'hd : v[3:0]};
    if (a == 8'h97 && v[6:5] == 2'h3) v[6:5] = 2'h0;
    return v;
  endfunction : model
  always @(posedge clk_i) if (arst_n_i) begin
    if (rvalid_o) begin
      checked++;
      if (rdata_o !== exp_q[0]) begin
        err_count++;
        $display("BAD rdata exp %h got %h", exp_q[0], rdata_o);
      end
      void'(exp_q.pop_front());
    end
    if (rd_i && !wr_i) exp_q.push_back(model(addr_i));
  end
  task automatic print_verdict;
    if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    #100000 err_count++;
    print_verdict();
  end
  initial begin
    void'($urandom(32'heab8));
    repeat (4) @(negedge clk_i);
    arst_n_i = 1;
    repeat (400) host.access(1'($urandom), 1'($urandom), 8'h88 + 8'($urandom % 24), 8'($urandom));
    host.access(0, 0, 0, 0);
    repeat (3) @(negedge clk_i);
    print_verdict();
  end
endmodule : test_module_advertisement_fields
